// ===== hw/ulm_pkg.sv
// constants and types for the uart line and modem status block
// assumes a single 100 MHz system clock and an apb register bus
package ulm_pkg;
  // apb byte offsets, one aligned word each
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_IER = 8'h04;
  localparam logic [7:0] OFF_ISR = 8'h08;
  localparam logic [7:0] OFF_LCR = 8'h0C;
  localparam logic [7:0] OFF_MCR = 8'h10;
  localparam logic [7:0] OFF_LSR = 8'h14;
  localparam logic [7:0] OFF_MSR = 8'h18;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  // modem control bit positions
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  // interrupt enable bit positions
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  // fifo control bit positions (write to the isr offset)
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  // modem status positions
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_RI = 2;
  localparam int MS_CD = 3;
  // interrupt identification codes
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LS = 4'h6;
  localparam logic [3:0] ISR_RX = 4'h4;
  localparam logic [3:0] ISR_TX = 4'h2;
  localparam logic [3:0] ISR_MS = 4'h0;
  // 16x oversampling
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [2:0] WLEN_BASE = 3'h4;
  localparam logic [2:0] IDX_TOP = 3'h7;

  typedef struct packed {
    logic dlab;
    logic brk;
    logic force_par;
    logic even;
    logic par_en;
    logic stop2;
    logic [1:0] wlen;
  } ulm_lcr_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulm_rx_ent_t;
endpackage

// ===== hw/ulm_uart.sv
// one uart channel: line format, parity, break, loopback, line and modem status
// assumes apb master on clk_sys; serial and modem inputs synchronous to clk_sys
// Operation
// - parity enable adds and checks parity bit
// - type bit: zero odd, one even
// - forced parity: mark if type zero, else space
// - break bit holds transmit output low outside loopback
// - divisor access bit selects divisor latches
// - dtr and rts pins drive inverted bits outside loopback
// - control bit two feeds ring path in loopback
// - interrupt pin enabled by select pin or bit
// - control bit four enables internal loopback
// - data ready while any character held
// - overrun flags, fifo contents left intact
// - overrun interrupts at once, tags at head
// - parity tag belongs to head character
// - framing tag belongs to head character
// - break stored once, held until line high
// - holding empty tracks transmit fifo empty
// - idle only when fifo and shifter empty
// - fifo error while any stored tag set
// - cts dsr cd deltas raise modem interrupt
// - ring delta only on ring input rising
// - cts high halts transmitter after character
// - status reads clear their pending interrupts
// - loopback status mirrors control bits
module ulm_uart #(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rx_in,
  output logic tx_out,
  // modem
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic dtr_n,
  output logic rts_n,
  // interrupt pin
  input wire logic interrupt_drive_select,
  output logic irq,
  output logic irq_oe
);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam int TPW = $clog2(TX_DEPTH);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulm_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} ulm_rx_st_t;

  function automatic logic [7:0] len_mask(input logic [1:0] wlen);
    len_mask = 8'hFF >> (3'h3 - {1'b0, wlen});
  endfunction

  // parity bit for a character under the current format
  function automatic logic par_bit(input logic [7:0] d, input ulm_pkg::ulm_lcr_t l);
    par_bit = l.force_par ? ~l.even : ((^(d & len_mask(l.wlen))) ^ ~l.even);
  endfunction

  ulm_pkg::ulm_lcr_t lcr_reg;
  logic [7:0] mcr_reg, ier_reg, divisor_low_reg, divisor_high_reg;
  logic fifo_en_reg, pready_reg, pslverr_reg, irq_reg, irq_oe_reg;
  logic [31:0] prdata_reg;
  logic tx_out_reg, dtr_n_reg, rts_n_reg;
  logic [15:0] baud_cnt_reg;
  logic tick_reg;

  // bus decode
  wire acc = psel & penable;
  wire done = acc & pready_reg;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  wire [7:0] wdat = pwdata[7:0];
  wire sel_data = paddr == ulm_pkg::OFF_DATA;
  wire sel_ier = paddr == ulm_pkg::OFF_IER;
  wire sel_isr = paddr == ulm_pkg::OFF_ISR;
  wire sel_lcr = paddr == ulm_pkg::OFF_LCR;
  wire sel_mcr = paddr == ulm_pkg::OFF_MCR;
  wire sel_lsr = paddr == ulm_pkg::OFF_LSR;
  wire sel_msr = paddr == ulm_pkg::OFF_MSR;
  wire mapped = sel_data | sel_ier | sel_isr | sel_lcr | sel_mcr | sel_lsr | sel_msr;
  wire dlab = lcr_reg.dlab;
  wire loop = mcr_reg[ulm_pkg::MCR_LOOP];
  wire wr_div_lo = wr & sel_data & dlab;
  wire wr_div_hi = wr & sel_ier & dlab;
  wire wr_ier = wr & sel_ier & ~dlab;

  // loopback modem paths
  wire aux_output_one_n = ~mcr_reg[ulm_pkg::MCR_OUT1];
  wire aux_output_two_n = ~mcr_reg[ulm_pkg::MCR_OUT2];
  wire cts_stat = loop ? mcr_reg[ulm_pkg::MCR_RTS] : ~cts_n;
  wire dsr_stat = loop ? mcr_reg[ulm_pkg::MCR_DTR] : ~dsr_n;
  wire ri_stat = loop ? ~aux_output_one_n : ~ri_n;
  wire cd_stat = loop ? ~aux_output_two_n : ~cd_n;
  wire [3:0] ms_stat = {cd_stat, ri_stat, dsr_stat, cts_stat};

  // baud tick at 16x bit rate
  wire [15:0] divisor = {divisor_high_reg, divisor_low_reg};
  wire tick_next = (divisor != 16'h0000) && (baud_cnt_reg == divisor - 16'h0001);

  // transmit fifo
  logic [7:0] tx_mem [TX_DEPTH];
  logic [TPW-1:0] tx_wp_reg, tx_rp_reg;
  logic [TPW:0] tx_cnt_reg;
  ulm_tx_st_t tx_st_reg;
  logic [3:0] tx_sub_reg;
  logic [2:0] tx_idx_reg;
  logic [7:0] tx_shift_reg;
  logic tx_line_reg, tx_par_reg, tx_stopx_reg, thre_pend_reg;
  wire [TPW:0] tx_cap = fifo_en_reg ? (TPW+1)'(TX_DEPTH) : (TPW+1)'(1);
  wire tx_rst = wr & sel_isr & wdat[ulm_pkg::FCR_EN] & wdat[ulm_pkg::FCR_TXRST];
  wire tx_push = wr & sel_data & ~dlab & (tx_cnt_reg < tx_cap);
  wire tx_empty = tx_cnt_reg == '0;
  wire tx_pop = tick_reg & (tx_st_reg == TX_IDLE) & ~tx_empty & cts_stat;
  wire tx_bit_end = tick_reg & (tx_sub_reg == ulm_pkg::OVS_LAST);
  wire [2:0] last_idx = ulm_pkg::WLEN_BASE + {1'b0, lcr_reg.wlen};
  wire temt = tx_empty & (tx_st_reg == TX_IDLE);
  wire tx_serial = lcr_reg.brk ? 1'b0 : tx_line_reg;

  // receive fifo with per-character tags
  ulm_pkg::ulm_rx_ent_t rx_mem [RX_DEPTH];
  logic [RPW-1:0] rx_wp_reg, rx_rp_reg;
  logic [RPW:0] rx_cnt_reg, rx_err_cnt_reg;
  ulm_rx_st_t rx_st_reg;
  logic [3:0] rx_sub_reg;
  logic [2:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic rx_pe_reg, rx_low_reg, overrun_reg, ls_ack_reg;
  wire [RPW:0] rx_cap = fifo_en_reg ? (RPW+1)'(RX_DEPTH) : (RPW+1)'(1);
  wire rx_src = loop ? tx_serial : rx_in;
  wire rx_bit_end = tick_reg & (rx_sub_reg == ulm_pkg::OVS_LAST);
  wire rx_done = rx_bit_end & (rx_st_reg == RX_STOP);
  wire rx_full = rx_cnt_reg >= rx_cap;
  wire rx_push = rx_done & ~rx_full;
  wire ovr_evt = rx_done & rx_full;
  wire [7:0] rx_data = rx_shift_reg >> (ulm_pkg::IDX_TOP - last_idx);
  wire [7:0] rx_next_shift = {rx_src, rx_shift_reg[7:1]};
  wire rx_brk = rx_low_reg & ~rx_src;
  ulm_pkg::ulm_rx_ent_t rx_ent;
  assign rx_ent = '{brk: rx_brk, fe: ~rx_src, pe: rx_pe_reg, data: rx_data};
  wire rx_rst = wr & sel_isr & wdat[ulm_pkg::FCR_EN] & wdat[ulm_pkg::FCR_RXRST];
  wire dready = rx_cnt_reg != '0;
  wire rx_pop = rd & sel_data & ~dlab & dready;
  ulm_pkg::ulm_rx_ent_t head;
  assign head = dready ? rx_mem[rx_rp_reg] : '0;
  wire head_err = head.brk | head.fe | head.pe;
  wire push_err = rx_ent.brk | rx_ent.fe | rx_ent.pe;
  wire pop_err = rx_pop & head_err;

  // status words
  logic [3:0] ms_prev_reg, ms_delta_reg;
  logic ms_init_reg;
  wire [7:0] line_status = {rx_err_cnt_reg != '0, temt, tx_empty, head.brk, head.fe, head.pe, overrun_reg, dready};
  wire [7:0] modem_status = {ms_stat, ms_delta_reg};
  wire [3:0] ms_set = ms_init_reg ? {ms_stat[3] ^ ms_prev_reg[3], ms_prev_reg[2] & ~ms_stat[2],
    ms_stat[1:0] ^ ms_prev_reg[1:0]} : 4'h0;
  wire [3:0] ms_clr = (rd & sel_msr) ? prdata_reg[3:0] : 4'h0;

  // interrupt sources in priority order
  wire ls_pend = ier_reg[ulm_pkg::IER_LS] & (overrun_reg | (head_err & ~ls_ack_reg));
  wire rx_pend = ier_reg[ulm_pkg::IER_RX] & dready;
  wire tx_pend = ier_reg[ulm_pkg::IER_TX] & thre_pend_reg;
  wire ms_pend = ier_reg[ulm_pkg::IER_MS] & (ms_delta_reg != 4'h0);
  wire [3:0] isr_id = ls_pend ? ulm_pkg::ISR_LS : rx_pend ? ulm_pkg::ISR_RX :
    tx_pend ? ulm_pkg::ISR_TX : ms_pend ? ulm_pkg::ISR_MS : ulm_pkg::ISR_NONE;
  wire thre_set = (tx_pop & (tx_cnt_reg == (TPW+1)'(1))) | (wr_ier & wdat[ulm_pkg::IER_TX] & tx_empty);
  wire thre_clr = (rd & sel_isr & (prdata_reg[3:0] == ulm_pkg::ISR_TX)) | tx_push;

  wire [7:0] rdata = sel_data ? (dlab ? divisor_low_reg : head.data) :
    sel_ier ? (dlab ? divisor_high_reg : ier_reg) :
    sel_isr ? {fifo_en_reg, fifo_en_reg, 2'b00, isr_id} :
    sel_lcr ? lcr_reg : sel_mcr ? mcr_reg : sel_lsr ? line_status : sel_msr ? modem_status : 8'h00;

  // registers and bus answer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lcr_reg <= ulm_pkg::LCR_RST;
      mcr_reg <= ulm_pkg::MCR_RST;
      ier_reg <= ulm_pkg::IER_RST;
      divisor_low_reg <= ulm_pkg::DIV_RST;
      divisor_high_reg <= ulm_pkg::DIV_RST;
      fifo_en_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      baud_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      if (wr & sel_lcr) lcr_reg <= wdat;
      if (wr & sel_mcr) mcr_reg <= wdat & 8'h1F;
      if (wr_ier) ier_reg <= wdat & 8'h0F;
      if (wr_div_lo) divisor_low_reg <= wdat;
      if (wr_div_hi) divisor_high_reg <= wdat;
      if (wr & sel_isr) fifo_en_reg <= wdat[ulm_pkg::FCR_EN];
      pready_reg <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~mapped;
      if (acc & ~pready_reg & ~pwrite) prdata_reg <= {24'h000000, rdata};
      baud_cnt_reg <= (tick_next | (divisor == 16'h0000)) ? 16'h0000 : baud_cnt_reg + 16'h0001;
      tick_reg <= tick_next;
    end
  end

  // pins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_out_reg <= 1'b1;
      dtr_n_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
    end else begin
      tx_out_reg <= loop | tx_serial;
      dtr_n_reg <= loop | ~mcr_reg[ulm_pkg::MCR_DTR];
      rts_n_reg <= loop | ~mcr_reg[ulm_pkg::MCR_RTS];
      irq_reg <= isr_id != ulm_pkg::ISR_NONE;
      irq_oe_reg <= interrupt_drive_select | mcr_reg[ulm_pkg::MCR_OUT2];
    end
  end

  // transmit fifo and shifter
  always_ff @(posedge clk_sys) begin
    if (tx_push) tx_mem[tx_wp_reg] <= wdat;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
      tx_st_reg <= TX_IDLE;
      tx_sub_reg <= 4'h0;
      tx_idx_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg <= 1'b1;
      tx_par_reg <= 1'b0;
      tx_stopx_reg <= 1'b0;
      thre_pend_reg <= 1'b0;
    end else begin
      thre_pend_reg <= thre_set | (thre_pend_reg & ~thre_clr);
      if (tx_rst) begin
        tx_wp_reg <= '0;
        tx_rp_reg <= '0;
        tx_cnt_reg <= '0;
      end else begin
        if (tx_push) tx_wp_reg <= (tx_wp_reg == TPW'(TX_DEPTH - 1)) ? '0 : tx_wp_reg + TPW'(1);
        if (tx_pop) tx_rp_reg <= (tx_rp_reg == TPW'(TX_DEPTH - 1)) ? '0 : tx_rp_reg + TPW'(1);
        tx_cnt_reg <= tx_cnt_reg + (TPW+1)'(tx_push) - (TPW+1)'(tx_pop);
      end
      if (tick_reg) tx_sub_reg <= (tx_st_reg == TX_IDLE) ? 4'h0 : tx_sub_reg + 4'h1;
      case (tx_st_reg)
        TX_IDLE: if (tx_pop) begin
          tx_shift_reg <= tx_mem[tx_rp_reg];
          tx_par_reg <= par_bit(tx_mem[tx_rp_reg], lcr_reg);
          tx_line_reg <= 1'b0;
          tx_st_reg <= TX_START;
        end
        TX_START: if (tx_bit_end) begin
          tx_line_reg <= tx_shift_reg[0];
          tx_idx_reg <= 3'h0;
          tx_st_reg <= TX_DATA;
        end
        TX_DATA: if (tx_bit_end) begin
          tx_shift_reg <= tx_shift_reg >> 1;
          if (tx_idx_reg == last_idx) begin
            tx_line_reg <= lcr_reg.par_en ? tx_par_reg : 1'b1;
            tx_stopx_reg <= lcr_reg.stop2;
            tx_st_reg <= lcr_reg.par_en ? TX_PAR : TX_STOP;
          end else begin
            tx_line_reg <= tx_shift_reg[1];
            tx_idx_reg <= tx_idx_reg + 3'h1;
          end
        end
        TX_PAR: if (tx_bit_end) begin
          tx_line_reg <= 1'b1;
          tx_st_reg <= TX_STOP;
        end
        TX_STOP: if (tx_bit_end) begin
          tx_stopx_reg <= 1'b0;
          if (!tx_stopx_reg) tx_st_reg <= TX_IDLE;
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  // receive fifo and shifter
  always_ff @(posedge clk_sys) begin
    if (rx_push) rx_mem[rx_wp_reg] <= rx_ent;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
      rx_err_cnt_reg <= '0;
      rx_st_reg <= RX_IDLE;
      rx_sub_reg <= 4'h0;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_pe_reg <= 1'b0;
      rx_low_reg <= 1'b0;
      overrun_reg <= 1'b0;
      ls_ack_reg <= 1'b0;
    end else begin
      overrun_reg <= ovr_evt | (overrun_reg & ~(rd & sel_lsr & prdata_reg[1]));
      ls_ack_reg <= (rd & sel_lsr) | (ls_ack_reg & ~rx_pop);
      if (rx_rst) begin
        rx_wp_reg <= '0;
        rx_rp_reg <= '0;
        rx_cnt_reg <= '0;
        rx_err_cnt_reg <= '0;
      end else begin
        if (rx_push) rx_wp_reg <= (rx_wp_reg == RPW'(RX_DEPTH - 1)) ? '0 : rx_wp_reg + RPW'(1);
        if (rx_pop) rx_rp_reg <= (rx_rp_reg == RPW'(RX_DEPTH - 1)) ? '0 : rx_rp_reg + RPW'(1);
        rx_cnt_reg <= rx_cnt_reg + (RPW+1)'(rx_push) - (RPW+1)'(rx_pop);
        rx_err_cnt_reg <= rx_err_cnt_reg + (RPW+1)'(rx_push & push_err) - (RPW+1)'(pop_err);
      end
      if (tick_reg) rx_sub_reg <= rx_sub_reg + 4'h1;
      case (rx_st_reg)
        RX_IDLE: if (tick_reg & ~rx_src) begin
          rx_sub_reg <= 4'h0;
          rx_st_reg <= RX_START;
        end
        RX_START: if (tick_reg && rx_sub_reg == ulm_pkg::OVS_MID) begin
          rx_sub_reg <= 4'h0;
          rx_idx_reg <= 3'h0;
          rx_low_reg <= 1'b1;
          rx_pe_reg <= 1'b0;
          rx_st_reg <= rx_src ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_bit_end) begin
          rx_shift_reg <= rx_next_shift;
          rx_low_reg <= rx_low_reg & ~rx_src;
          if (rx_idx_reg == last_idx) rx_st_reg <= lcr_reg.par_en ? RX_PAR : RX_STOP;
          else rx_idx_reg <= rx_idx_reg + 3'h1;
        end
        RX_PAR: if (rx_bit_end) begin
          rx_pe_reg <= rx_src != par_bit(rx_data, lcr_reg);
          rx_low_reg <= rx_low_reg & ~rx_src;
          rx_st_reg <= RX_STOP;
        end
        // a low stop bit waits for the line to go high, so its tail is not taken as a start
        RX_STOP: if (rx_bit_end) rx_st_reg <= rx_src ? RX_IDLE : RX_BRK;
        RX_BRK: if (rx_src) rx_st_reg <= RX_IDLE;
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // modem status deltas; set wins over the read clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ms_prev_reg <= 4'h0;
      ms_delta_reg <= 4'h0;
      ms_init_reg <= 1'b0;
    end else begin
      ms_init_reg <= 1'b1;
      ms_prev_reg <= ms_stat;
      ms_delta_reg <= (ms_delta_reg & ~ms_clr) | ms_set;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_out = tx_out_reg;
  assign dtr_n = dtr_n_reg;
  assign rts_n = rts_n_reg;
  assign irq = irq_reg;
  assign irq_oe = irq_oe_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_break_low: assert property (lcr_reg.brk & ~loop |=> ~tx_out_reg) else $error("break not low");
  a_loop_idle: assert property (loop |=> tx_out_reg & dtr_n_reg & rts_n_reg)
    else $error("loopback pins not idle");
  a_dtr_drive: assert property (~loop & mcr_reg[ulm_pkg::MCR_DTR] |=> ~dtr_n_reg)
    else $error("dtr not driven low");
  a_interrupt_drive_select_oe: assert property (interrupt_drive_select |=> irq_oe_reg) else $error("irq not enabled");
  a_overrun_set: assert property (ovr_evt |=> overrun_reg) else $error("overrun missed");
  a_fifo_intact: assert property (ovr_evt & ~rx_pop & ~rx_rst |=> rx_cnt_reg == $past(rx_cnt_reg))
    else $error("fifo changed on overrun");
  a_idle_empty: assert property (temt |-> line_status[5]) else $error("idle while holding full");
  a_cts_halt: assert property (~cts_stat & (tx_st_reg == TX_IDLE) |=> tx_st_reg == TX_IDLE)
    else $error("started while cts high");
  a_ri_edge: assert property ($rose(ms_delta_reg[ulm_pkg::MS_RI]) |-> $past(ms_prev_reg[2]) & ~$past(ri_stat))
    else $error("ring delta without trailing edge");
  a_cts_delta: assert property (ms_init_reg & (cts_stat != ms_prev_reg[0]) |=> ms_delta_reg[0])
    else $error("cts delta missed");
  a_ls_irq: assert property (ier_reg[ulm_pkg::IER_LS] & overrun_reg |=> irq_reg)
    else $error("line status irq missing");

  c_tx_char: cover property (tx_st_reg == TX_STOP ##1 tx_st_reg == TX_IDLE);
  c_rx_char: cover property (rx_push);
  c_rx_brk: cover property (rx_push & rx_brk);
  c_overrun: cover property (ovr_evt);
  c_ms_irq: cover property (ms_pend ##1 irq_reg);
endmodule

// ===== test/uart_line_modem_status_tb.sv
// self-checking bench for the uart line and modem status block
// assumes the far-end model ulm_far_end and apb answers with pready
module uart_line_modem_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, psel, penable, pwrite, sel_pin, sl, p;
  logic [7:0] paddr, d;
  logic [31:0] pwdata, prdata, rd_val;
  logic pready, pslverr, rx_in, tx_out, cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, irq, irq_oe;
  logic [9:0] bits;
  logic [3:0] pins, prev, delta;
  logic [7:0] rxq[$];
  int failures, checks, cyc;
  ulm_uart uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .tx_out(tx_out), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .dtr_n(dtr_n), .rts_n(rts_n),
    .interrupt_drive_select(sel_pin), .irq(irq), .irq_oe(irq_oe));
  ulm_far_end far (.clk_sys(clk_sys), .tx_out(tx_out), .rx_in(rx_in), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .cd_n(cd_n));
  task automatic test_done();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd_val = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v});
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, {24'h0, exp & m}, rd_val & {24'h0, m});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc == 40000) begin
        failures++;
        test_done();
      end
    end
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, sel_pin, paddr, pwdata} = '0;
    failures = 0;
    checks = 0;
    void'($urandom(60012));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd("line_status", ulm_pkg::OFF_LSR, 8'hFF, 8'h60);
    rd("modem_status", ulm_pkg::OFF_MSR, 8'hFF, 8'h00);
    rd("unmapped", 8'h1C, 8'hFF, 8'h00);
    chk("pslverr", 1, sl);
    wr(ulm_pkg::OFF_LCR, 8'h80);
    wr(ulm_pkg::OFF_DATA, 8'h01);
    wr(ulm_pkg::OFF_IER, 8'h00);
    rd("divisor_low", ulm_pkg::OFF_DATA, 8'hFF, 8'h01);
    wr(ulm_pkg::OFF_LCR, 8'h03);
    wr(ulm_pkg::OFF_IER, 8'h08);
    rd("interrupt_enable", ulm_pkg::OFF_IER, 8'h0F, 8'h08);
    for (int k = 0; k < 16; k++) begin
      // bus runs in 16-style mode, so either select level is legal
      sel_pin <= k[3];
      wr(ulm_pkg::OFF_MCR, {4'h0, k[2], 1'b0, k[1:0]});
      repeat (2) @(posedge clk_sys);
      chk("dtr_rts_oe", {29'h0, ~k[0], ~k[1], k[3] | k[2]}, {29'h0, dtr_n, rts_n, irq_oe});
    end
    wr(ulm_pkg::OFF_MCR, 8'h00);
    prev = 4'hF;
    for (int k = 0; k < 8; k++) begin
      pins = 4'($urandom);
      far.modem(pins);
      delta = ((prev ^ pins) & 4'hB) | (pins & ~prev & 4'h4);
      repeat (4) @(posedge clk_sys);
      chk("irq", {31'h0, |delta}, {31'h0, irq});
      rd("modem_status", ulm_pkg::OFF_MSR, 8'hFF, {~pins, delta});
      repeat (2) @(posedge clk_sys);
      chk("irq_cleared", 0, irq);
      prev = pins;
    end
    far.modem(4'hE);
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      p = !k[0] ? 1'b1 : k[2] ? ~k[1] : (k[1] ? ^d : ~^d);
      repeat (16) @(posedge clk_sys);
      wr(ulm_pkg::OFF_LCR, 8'h03 | 8'(k << 3));
      fork
        far.recv(bits);
        wr(ulm_pkg::OFF_DATA, d);
      join
      chk("tx_frame", {22'h0, 1'b1, p, d}, {22'h0, bits});
    end
    repeat (16) @(posedge clk_sys);
    far.modem(4'hF);
    fork
      far.recv(bits);
      begin
        wr(ulm_pkg::OFF_DATA, 8'hA5);
        repeat (40) @(posedge clk_sys);
        chk("tx_halted", 1, tx_out);
        far.modem(4'hE);
      end
    join
    chk("tx_resumed", {22'h0, 2'b10, 8'hA5}, {22'h0, bits});
    repeat (16) @(posedge clk_sys);
    wr(ulm_pkg::OFF_LCR, 8'h5B);
    repeat (2) @(posedge clk_sys);
    chk("tx_break", 0, tx_out);
    wr(ulm_pkg::OFF_LCR, 8'h1B);
    repeat (2) @(posedge clk_sys);
    chk("tx_idle", 1, tx_out);
    // second character lands while the one-deep receiver is full and is dropped
    d = 8'($urandom);
    rxq.push_back(d);
    far.send(d, 1'b1, ^d, 1'b1);
    far.send(~d, 1'b1, ~^d, 1'b1);
    rd("line_status", ulm_pkg::OFF_LSR, 8'hFF, 8'h63);
    rd("rx_data", ulm_pkg::OFF_DATA, 8'hFF, rxq.pop_front());
    for (int k = 0; k < 2; k++) begin
      // a set bit keeps a low-stop frame from reading as a break
      d = 8'($urandom) | 8'h10;
      rxq.push_back(d);
      far.send(d, 1'b1, ^d ^ !k[0], !k[0]);
      rd("line_status", ulm_pkg::OFF_LSR, 8'hFF, k[0] ? 8'hE9 : 8'hE5);
      rd("rx_data", ulm_pkg::OFF_DATA, 8'hFF, rxq.pop_front());
    end
    far.send(8'h00, 1'b1, 1'b0, 1'b0);
    rd("line_status", ulm_pkg::OFF_LSR, 8'hFF, 8'hF9);
    rd("rx_data", ulm_pkg::OFF_DATA, 8'hFF, 8'h00);
    rd("line_status", ulm_pkg::OFF_LSR, 8'hFF, 8'h60);
    for (int k = 0; k < 16; k++) begin
      wr(ulm_pkg::OFF_MCR, {4'h1, k[3:0]});
      rd("loop_status", ulm_pkg::OFF_MSR, 8'hF0, {k[3], k[2], k[0], k[1], 4'h0});
    end
    wr(ulm_pkg::OFF_MCR, 8'h13);
    d = 8'($urandom);
    wr(ulm_pkg::OFF_DATA, d);
    repeat (240) @(posedge clk_sys);
    chk("loop_pins", 3'b111, {tx_out, dtr_n, rts_n});
    rd("loop_ready", ulm_pkg::OFF_LSR, 8'h1F, 8'h01);
    rd("loop_data", ulm_pkg::OFF_DATA, 8'hFF, d);
    test_done();
  end
endmodule

// ===== test/ulm_far_end.sv
// far-end serial device: sends frames on rx_in, decodes tx_out, drives modem inputs
// assumes divisor 1, so a bit lasts 16 clk_sys cycles, and 8-bit words
module ulm_far_end (
  // clock
  input wire logic clk_sys,
  // serial line
  input wire logic tx_out,
  output logic rx_in,
  // modem
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic cd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_in = 1'b1;
    {cd_n, ri_n, dsr_n, cts_n} = 4'hF;
  end
  // cts level also gates the transmitter
  task automatic modem(input logic [3:0] v);
    @(posedge clk_sys);
    {cd_n, ri_n, dsr_n, cts_n} <= v;
  endtask
  // start, data lsb first, parity, stop; without parity the slot idles high
  task automatic send(input logic [7:0] d, input logic has_par, input logic par, input logic stop);
    logic [10:0] f;
    f = has_par ? {stop, par, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      rx_in <= f[i];
      repeat (15) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rx_in <= 1'b1;
  endtask
  // samples mid-bit: 8 data bits, then parity or stop, then the next slot
  task automatic recv(output logic [9:0] b);
    @(negedge tx_out);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge clk_sys);
      b[i] = tx_out;
    end
  endtask
endmodule
